/* logic/tlb_low_pkg.sv */
package tlb_low_pkg;
  // Special-register selector of the entry low word
  localparam logic [15:0] SEL_ENTRY_LOW = 16'h1002;
  // Entry count and index width
  localparam int ENTRY_COUNT = 64;
  localparam int INDEX_W = 6;
  // Field positions, bit 0 is the most significant bit of the word
  localparam int PAGE_NUM_MSB = 0;
  localparam int PAGE_NUM_LSB = 21;
  localparam int PAGE_NUM_W = 22;
  localparam int EXEC_BIT = 22;
  localparam int WR_BIT = 23;
  localparam int ZONE_SEL_MSB = 24;
  localparam int ZONE_SEL_LSB = 27;
  localparam int WT_BIT = 28;
  localparam int CI_BIT = 29;
  localparam int MC_BIT = 30;
  localparam int GD_BIT = 31;
  // Constant attribute values
  localparam logic WT_VALUE = 1'b1;
  localparam logic MC_VALUE = 1'b0;
  // Entry value at configuration load
  localparam logic [31:0] ENTRY_LOAD_VALUE = 32'h00000000;
  // Zone protect codes
  localparam logic [1:0] ZONE_DENY_USER = 2'h0;
  localparam logic [1:0] ZONE_FULL = 2'h3;
  localparam logic [1:0] ZONE_FULL_PRIV = 2'h2;
  // Configuration level with full translation
  localparam logic [1:0] CFG_FULL_XLAT = 2'h3;
  // Page size code width
  localparam int SIZE_W = 3;
endpackage

/* logic/tlb_entry_low_attributes.sv */
`timescale 1ns/1ps
module tlb_entry_low_attributes (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] translationConfigLevel,
  input wire logic sprWrite,
  input wire logic sprRead,
  input wire logic [15:0] sprSelect,
  input wire logic [31:0] sprWriteData,
  input wire logic [tlb_low_pkg::INDEX_W-1:0] entryIndexReg,
  input wire logic lookupValid,
  input wire logic lookupHit,
  input wire logic [tlb_low_pkg::INDEX_W-1:0] lookupIndex,
  input wire logic lookupEntryValid,
  input wire logic [tlb_low_pkg::SIZE_W-1:0] lookupSize,
  input wire logic [31:0] virtualAddr,
  input wire logic isFetch,
  input wire logic isStore,
  input wire logic userMode,
  input wire logic [31:0] zoneProtectReg,
  output logic [31:0] sprReadData,
  output logic [31:0] physicalAddr,
  output logic xlatValid,
  output logic instrStorageFault,
  output logic dataStorageFault,
  output logic cacheInhibit,
  output logic guarded
);
  // Entry array: no reset, only the initial load value
  logic [31:0] entryMem [tlb_low_pkg::ENTRY_COUNT];
  initial
  begin
    for (int i = 0; i < tlb_low_pkg::ENTRY_COUNT; i++)
      entryMem[i] = tlb_low_pkg::ENTRY_LOAD_VALUE;
  end

  logic selHit;
  logic [31:0] storeWord;
  assign selHit = (sprSelect == tlb_low_pkg::SEL_ENTRY_LOW);

  // Fixed bits are forced so stored value never disagrees
  always_comb
  begin
    storeWord = sprWriteData;
    storeWord[31-tlb_low_pkg::WT_BIT] = tlb_low_pkg::WT_VALUE;
    storeWord[31-tlb_low_pkg::MC_BIT] = tlb_low_pkg::MC_VALUE;
  end

  // Memory write port, kept resetless on purpose
  always_ff @(posedge clk)
  begin
    if (sprWrite && selHit)
      entryMem[entryIndexReg] <= storeWord;
  end

  // Lookup field extraction; bit n of docs is word bit 31-n
  logic [31:0] hitWord;
  logic [tlb_low_pkg::PAGE_NUM_W-1:0] pageNumber;
  logic execPermit;
  logic wrPermit;
  logic [3:0] zoneSelect;
  logic [1:0] zoneCode;
  logic [31:0] keepMask;
  logic effValid;
  logic effExec;
  logic effWr;
  assign hitWord = entryMem[lookupIndex];
  assign pageNumber = hitWord[31-tlb_low_pkg::PAGE_NUM_MSB -: tlb_low_pkg::PAGE_NUM_W];
  assign execPermit = hitWord[31-tlb_low_pkg::EXEC_BIT];
  assign wrPermit = hitWord[31-tlb_low_pkg::WR_BIT];
  assign zoneSelect = hitWord[31-tlb_low_pkg::ZONE_SEL_MSB -: 4];
  // Zone 0 sits in the top two bits of the protect word
  assign zoneCode = zoneProtectReg[31-2*zoneSelect -: 2];

  // Zone override of valid, write and execute
  always_comb
  begin
    effValid = lookupEntryValid;
    effExec = execPermit;
    effWr = wrPermit;
    if (userMode)
    begin
      case (zoneCode)
        tlb_low_pkg::ZONE_DENY_USER:
        begin
          effValid = 1'b0;
        end
        tlb_low_pkg::ZONE_FULL:
        begin
          effExec = 1'b1;
          effWr = 1'b1;
        end
        default:
        begin
          // Codes 01 and 10 leave the entry's own bits in force
          effValid = lookupEntryValid;
        end
      endcase
    end
    else
    begin
      case (zoneCode)
        tlb_low_pkg::ZONE_FULL, tlb_low_pkg::ZONE_FULL_PRIV:
        begin
          effExec = 1'b1;
          effWr = 1'b1;
        end
        default:
        begin
          // Privileged mode never denies through the zone
          effValid = lookupEntryValid;
        end
      endcase
    end
  end

  // Page size 1 KB << 2*size; offset bits come from the virtual address
  always_comb
  begin
    keepMask = 32'hFFFFFFFF << (5'd10 + {lookupSize, 1'b0});
  end

  logic [31:0] next_physicalAddr;
  logic next_xlatValid;
  logic next_instrStorageFault;
  logic next_dataStorageFault;
  logic next_cacheInhibit;
  logic next_guarded;
  logic [31:0] next_sprReadData;
  logic fullXlat;
  assign fullXlat = (translationConfigLevel == tlb_low_pkg::CFG_FULL_XLAT);

  // Translation result, one cycle after the lookup
  always_comb
  begin
    next_xlatValid = lookupValid && lookupHit && effValid;
    next_physicalAddr = virtualAddr;
    if (fullXlat)
      next_physicalAddr = ({pageNumber, 10'h000} & keepMask) | (virtualAddr & ~keepMask);
    next_instrStorageFault = next_xlatValid && isFetch && !effExec;
    next_dataStorageFault = next_xlatValid && isStore && !effWr;
    next_cacheInhibit = next_xlatValid && hitWord[31-tlb_low_pkg::CI_BIT];
    next_guarded = next_xlatValid && hitWord[31-tlb_low_pkg::GD_BIT];
    next_sprReadData = sprReadData;
    if (sprRead && selHit)
    begin
      next_sprReadData = entryMem[entryIndexReg];
      next_sprReadData[31-tlb_low_pkg::WT_BIT] = tlb_low_pkg::WT_VALUE;
      next_sprReadData[31-tlb_low_pkg::MC_BIT] = tlb_low_pkg::MC_VALUE;
    end
  end

  // Output registers; reset touches outputs, never the entries
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      physicalAddr <= 32'h00000000;
      xlatValid <= 1'b0;
      instrStorageFault <= 1'b0;
      dataStorageFault <= 1'b0;
      cacheInhibit <= 1'b0;
      guarded <= 1'b0;
      sprReadData <= 32'h00000000;
    end
    else
    begin
      physicalAddr <= next_physicalAddr;
      xlatValid <= next_xlatValid;
      instrStorageFault <= next_instrStorageFault;
      dataStorageFault <= next_dataStorageFault;
      cacheInhibit <= next_cacheInhibit;
      guarded <= next_guarded;
      sprReadData <= next_sprReadData;
    end
  end

  // Checks
  a_wt_reads_one: assert property (@(posedge clk) disable iff (!resetn)
    $past(sprRead && selHit) |-> sprReadData[31-tlb_low_pkg::WT_BIT])
    else $error("write-through bit read as zero");
  a_mc_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
    $past(sprRead && selHit) |-> !sprReadData[31-tlb_low_pkg::MC_BIT])
    else $error("coherence bit read as one");
  a_ifetch_fault: assert property (@(posedge clk) disable iff (!resetn)
    instrStorageFault |-> xlatValid && $past(isFetch))
    else $error("fetch fault without fetch");
  a_store_fault: assert property (@(posedge clk) disable iff (!resetn)
    dataStorageFault |-> xlatValid && $past(isStore))
    else $error("store fault without store");
  a_user_deny: assert property (@(posedge clk) disable iff (!resetn)
    (lookupValid && userMode && zoneCode == tlb_low_pkg::ZONE_DENY_USER) |=> !xlatValid)
    else $error("user zone 00 did not deny");
  a_priv_grant: assert property (@(posedge clk) disable iff (!resetn)
    (!userMode && zoneCode[1]) |=> !instrStorageFault && !dataStorageFault)
    else $error("privileged zone grant faulted");
  a_guard_ci: assert property (@(posedge clk) disable iff (!resetn)
    (guarded || cacheInhibit) |-> xlatValid)
    else $error("attribute without translation");
  a_wr_readback: assert property (@(posedge clk) disable iff (!resetn)
    (sprWrite && selHit) ##1 (sprRead && selHit && !sprWrite && $stable(entryIndexReg))
    |=> sprReadData[31:4] == $past(sprWriteData[31:4], 2) && sprReadData[2] == $past(sprWriteData[2], 2)
    && sprReadData[0] == $past(sprWriteData[0], 2))
    else $error("readback mismatch");
  a_page_offset: assert property (@(posedge clk) disable iff (!resetn)
    lookupValid |=> physicalAddr[9:0] == $past(virtualAddr[9:0]))
    else $error("page offset altered");

  // Address forming per configuration level and page size
  a_pa_passthru: assert property (@(posedge clk) disable iff (!resetn)
    !fullXlat |=> physicalAddr == $past(virtualAddr))
    else $error("address not passed through");
  a_pa_page: assert property (@(posedge clk) disable iff (!resetn)
    (fullXlat && lookupSize == 3'h0) |=> physicalAddr[31:10] == $past(pageNumber))
    else $error("page number not used");
  // Largest page keeps only the top eight page bits
  a_pa_unused: assert property (@(posedge clk) disable iff (!resetn)
    (fullXlat && lookupSize == 3'h7) |=> physicalAddr[23:0] == $past(virtualAddr[23:0]))
    else $error("unused page bits leaked");

  // Permission checks against the effective bits and the entry's own execute and write bits
  a_exec_fault_set: assert property (@(posedge clk) disable iff (!resetn)
    (lookupValid && lookupHit && effValid && isFetch && !effExec) |=> instrStorageFault)
    else $error("fetch fault missing");
  a_exec_allow: assert property (@(posedge clk) disable iff (!resetn)
    execPermit |=> !instrStorageFault)
    else $error("fetch faulted on executable page");
  a_store_fault_set: assert property (@(posedge clk) disable iff (!resetn)
    (lookupValid && lookupHit && effValid && isStore && !effWr) |=> dataStorageFault)
    else $error("store fault missing");
  a_write_allow: assert property (@(posedge clk) disable iff (!resetn)
    wrPermit |=> !dataStorageFault)
    else $error("store faulted on writable page");

  // Zone code effects in both modes
  a_user_grant_wr: assert property (@(posedge clk) disable iff (!resetn)
    (userMode && zoneCode == tlb_low_pkg::ZONE_FULL) |=> !dataStorageFault)
    else $error("user zone 11 store faulted");
  a_user_grant_ex: assert property (@(posedge clk) disable iff (!resetn)
    (userMode && zoneCode == tlb_low_pkg::ZONE_FULL) |=> !instrStorageFault)
    else $error("user zone 11 fetch faulted");
  a_user_mid_codes: assert property (@(posedge clk) disable iff (!resetn)
    (userMode && (zoneCode == 2'h1 || zoneCode == 2'h2) && lookupValid && lookupHit && lookupEntryValid)
    |=> xlatValid)
    else $error("user zone 01 or 10 denied");
  a_priv_valid_kept: assert property (@(posedge clk) disable iff (!resetn)
    (!userMode && lookupValid && lookupHit && lookupEntryValid) |=> xlatValid)
    else $error("privileged access denied");
  a_priv_low_codes: assert property (@(posedge clk) disable iff (!resetn)
    (!userMode && !zoneCode[1] && lookupValid && lookupHit && lookupEntryValid && isStore && !wrPermit)
    |=> dataStorageFault)
    else $error("privileged low zone overrode write");
  a_invalid_entry: assert property (@(posedge clk) disable iff (!resetn)
    !lookupEntryValid |=> !xlatValid)
    else $error("invalid entry translated");
  a_no_hit_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !(lookupValid && lookupHit) |=> !xlatValid)
    else $error("translation without hit");
  a_deny_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !xlatValid |-> !instrStorageFault && !dataStorageFault)
    else $error("fault without translation");

  // Attributes follow the hit entry
  a_ci_follow: assert property (@(posedge clk) disable iff (!resetn)
    (lookupValid && lookupHit && effValid) |=> cacheInhibit == $past(hitWord[31-tlb_low_pkg::CI_BIT]))
    else $error("cache inhibit wrong");
  a_gd_follow: assert property (@(posedge clk) disable iff (!resetn)
    (lookupValid && lookupHit && effValid) |=> guarded == $past(hitWord[31-tlb_low_pkg::GD_BIT]))
    else $error("guarded wrong");

  // Register port: read data holds, fixed bits stored constant
  a_read_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(sprRead && selHit) |=> $stable(sprReadData))
    else $error("read data changed without read");
  a_wt_stored: assert property (@(posedge clk) disable iff (!resetn)
    (sprWrite && selHit) |=> entryMem[$past(entryIndexReg)][31-tlb_low_pkg::WT_BIT])
    else $error("write-through bit stored as zero");
  a_mc_stored: assert property (@(posedge clk) disable iff (!resetn)
    (sprWrite && selHit) |=> !entryMem[$past(entryIndexReg)][31-tlb_low_pkg::MC_BIT])
    else $error("coherence bit stored as one");

  c_cfg_passthru: cover property (@(posedge clk) lookupValid && !fullXlat);
  c_fetch_fault: cover property (@(posedge clk) instrStorageFault);
  c_store_fault: cover property (@(posedge clk) dataStorageFault);
  c_user_deny: cover property (@(posedge clk) lookupValid && lookupHit && userMode && zoneCode == 2'h0);
  c_spr_rw: cover property (@(posedge clk) (sprWrite && selHit) ##1 (sprRead && selHit));
endmodule

/* verif/test_tlb_entry_low_attributes.sv */
`timescale 1ns/1ps
module test_tlb_entry_low_attributes;
  typedef struct {int cyc; int kind; logic [31:0] val;} note_t;
  note_t notes[$];
  logic clk = 1'b0, resetn = 1'b0, sprWrite = 1'b0, sprRead = 1'b0, lookupValid = 1'b0, lookupHit = 1'b0;
  logic lookupEntryValid = 1'b0, isFetch = 1'b0, isStore = 1'b0, userMode = 1'b0;
  logic xlatValid, instrStorageFault, dataStorageFault, cacheInhibit, guarded;
  logic [1:0] cfg = 2'h3;
  logic [2:0] lookupSize = 3'h0;
  logic [15:0] sprSelect = 16'h0000;
  logic [5:0] entryIndexReg = 6'h00, lookupIndex = 6'h00;
  logic [31:0] sprWriteData = 32'h0, virtualAddr = 32'h0, zoneProtectReg = 32'h0, sprReadData, physicalAddr;
  logic [31:0] rnd = 32'h00000038, r, d;
  logic [31:0] entry [64];
  logic [2:0] pageSize [64];
  int cyc = 0, miscompares = 0, total_checks = 0;
  tlb_entry_low_attributes uut (.clk(clk), .resetn(resetn), .translationConfigLevel(cfg), .sprWrite(sprWrite),
    .sprRead(sprRead), .sprSelect(sprSelect), .sprWriteData(sprWriteData), .entryIndexReg(entryIndexReg),
    .lookupValid(lookupValid), .lookupHit(lookupHit), .lookupIndex(lookupIndex), .lookupEntryValid(lookupEntryValid),
    .lookupSize(lookupSize), .virtualAddr(virtualAddr), .isFetch(isFetch), .isStore(isStore), .userMode(userMode),
    .zoneProtectReg(zoneProtectReg), .sprReadData(sprReadData), .physicalAddr(physicalAddr), .xlatValid(xlatValid),
    .instrStorageFault(instrStorageFault), .dataStorageFault(dataStorageFault), .cacheInhibit(cacheInhibit),
    .guarded(guarded));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr();
    for (int k = 0; k < 8; k++) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Result expected just after the edge that follows the request
  task automatic note(int kind, logic [31:0] val);
    notes.push_back('{cyc + 1, kind, val});
  endtask
  task automatic spr(logic wr, logic [15:0] sel, logic [5:0] idx, logic [31:0] dat);
    @(posedge clk);
    #1;
    sprWrite = wr;
    sprRead = !wr;
    sprSelect = sel;
    entryIndexReg = idx;
    sprWriteData = dat;
    if (!wr) note(0, entry[idx] | 32'h00000008);
    else if (sel == tlb_low_pkg::SEL_ENTRY_LOW) entry[idx] = {dat[31:4], 1'b1, dat[2], 1'b0, dat[0]};
  endtask
  task automatic lookup(logic [5:0] idx);
    logic [31:0] e, m, q;
    logic [1:0] z;
    logic ev, full, xv;
    @(posedge clk);
    #1;
    sprWrite = 1'b0;
    sprRead = 1'b0;
    q = lfsr();
    e = entry[idx];
    lookupIndex = idx;
    lookupSize = pageSize[idx];
    {lookupEntryValid, isFetch, isStore, userMode} = q[3:0];
    lookupValid = q[4] | q[5];
    lookupHit = q[6] | q[7];
    cfg = q[8] ? 2'h3 : q[10:9];
    virtualAddr = lfsr();
    zoneProtectReg = lfsr();
    z = zoneProtectReg[31 - 2 * e[7:4] -: 2];
    ev = lookupEntryValid & !(userMode & z == 2'h0);
    full = userMode ? z == 2'h3 : z[1];
    xv = lookupValid & lookupHit & ev;
    m = ~((32'h00000400 << 2 * lookupSize) - 1);
    if (cfg != 2'h3 || xv) note(1, cfg == 2'h3 ? ({e[31:10], 10'h000} & m) | (virtualAddr & ~m) : virtualAddr);
    if (cfg == 2'h3) note(2, {xv, xv & isFetch & !(e[9] | full), xv & isStore & !(e[8] | full)});
    if (cfg == 2'h3 && xv) note(3, {e[2], e[0]});
  endtask
  task automatic idle();
    @(posedge clk);
    #1;
    sprWrite = 1'b0;
    sprRead = 1'b0;
    lookupValid = 1'b0;
  endtask
  // Cycle count and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // Checker side: every due note, oldest first, against the settled outputs
  always @(posedge clk)
  begin
    note_t n;
    logic [31:0] seen;
    #2;
    while (notes.size() > 0 && notes[0].cyc <= cyc)
    begin
      n = notes.pop_front();
      seen = n.kind == 0 ? sprReadData : n.kind == 1 ? physicalAddr : n.kind == 2 ?
        {29'h0, xlatValid, instrStorageFault, dataStorageFault} : {30'h0, cacheInhibit, guarded};
      total_checks++;
      if (seen !== n.val)
      begin
        $display("wrong value output %0d: expected %h seen %h", n.kind, n.val, seen);
        miscompares++;
      end
    end
  end
  // Main sequence; entries start cleared, as after configuration load
  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      entry[i] = 32'h00000000;
      pageSize[i] = 3'h0;
    end
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) spr(1'b0, tlb_low_pkg::SEL_ENTRY_LOW, i[5:0], 32'h0);
    // Unused page bits kept clear, as software must
    for (int i = 0; i < 48; i++)
    begin
      r = lfsr();
      pageSize[r[5:0]] = r[8:6];
      d = lfsr() & ~(((32'h1 << 2 * r[8:6]) - 1) << 10);
      spr(1'b1, tlb_low_pkg::SEL_ENTRY_LOW, r[5:0], d);
      spr(1'b0, tlb_low_pkg::SEL_ENTRY_LOW, r[5:0], 32'h0);
      spr(1'b1, 16'h1001, r[5:0], ~d);
      spr(1'b0, tlb_low_pkg::SEL_ENTRY_LOW, r[5:0], 32'h0);
    end
    // Let the last read be checked before reset clears it
    idle();
    idle();
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 64; i++) spr(1'b0, tlb_low_pkg::SEL_ENTRY_LOW, i[5:0], 32'h0);
    for (int i = 0; i < 400; i++) lookup(lfsr() & 32'h0000003F);
    idle();
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
